/* File: spsc_pkg.sv */
package spsc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CHIP_CFG_24 = 8'h00;
  localparam logic [7:0] OFS_CHIP_CFG_26 = 8'h04;
  localparam logic [7:0] OFS_HS_STAT_A   = 8'h08;
  localparam logic [7:0] OFS_HS_STAT_B   = 8'h0C;
  localparam logic [7:0] OFS_HS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_CFG_PORT    = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHIP_CONFIG_REG_24_PNP_CLR  = 0;
  localparam int CHIP_CONFIG_REG_24_ROM_EN   = 1;
  localparam int CHIP_CONFIG_REG_24_CLK48_EN = 6;
  localparam int CHIP_CONFIG_REG_26_PORT_SEL = 6;
  localparam int HS_CTS        = 4;
  localparam int HS_DSR        = 5;
  localparam int HS_RI         = 6;
  localparam int HS_DCD        = 7;
  localparam int CTRL_RTS_A    = 0;
  localparam int CTRL_DTR_A    = 1;
  localparam int CTRL_RTS_B    = 2;
  localparam int CTRL_DTR_B    = 3;

  // Writable bits and reset values
  localparam logic [7:0] CHIP_CONFIG_REG_24_WMASK = 8'h43;
  localparam logic [7:0] CHIP_CONFIG_REG_26_WMASK = 8'h40;
  localparam logic [3:0] CTRL_RESET = 4'hF;

  // ----------------------------------------------------------------
  // Configuration port addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_PORT_DEFAULT = 8'h2E;
  localparam logic [7:0] CFG_PORT_ALT     = 8'h4E;

  // ----------------------------------------------------------------
  // Synchronised input positions
  // ----------------------------------------------------------------
  localparam int SYNC_W      = 12;
  localparam int IN_CTS_A    = 0;
  localparam int IN_CTS_B    = 1;
  localparam int IN_DSR_A    = 2;
  localparam int IN_DSR_B    = 3;
  localparam int IN_DCD_A    = 4;
  localparam int IN_DCD_B    = 5;
  localparam int IN_RI_A     = 6;
  localparam int IN_RI_B     = 7;
  localparam int IN_STR_PORT = 8;
  localparam int IN_STR_PNP  = 9;
  localparam int IN_STR_ROM  = 10;
  localparam int IN_STR_C48  = 11;

  // Cycles after reset release before straps are taken
  localparam int SETTLE_CYCLES = 4;

  // ----------------------------------------------------------------
  // Capture sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } spsc_state_t;

endpackage

/* File: spsc_sync_if.sv */
`timescale 1ns/1ps

interface spsc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport user (output raw, input level);
  modport sync (input raw, output level);
endinterface

/* File: spsc_sync.sv */
`timescale 1ns/1ps

module spsc_sync #(
  parameter int W = 1
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  spsc_sync_if.sync sif
);

  // ----------------------------------------------------------------
  // Three-stage pin synchroniser with agreement filter
  // ----------------------------------------------------------------
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] level;

  initial
  begin
    if (W < 1)
      $error("spsc_sync: W must be at least 1");
  end

  // Stage one is read only by stage two
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= sif.raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes only once stages two and three agree
  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          level[i] <= 1'b0;
        else if (s2[i] == s3[i])
          level[i] <= s3[i];
      end
    end
  endgenerate

  assign sif.level = level;

endmodule

/* File: spsc_top.sv */
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps

module spsc_top #(
  parameter logic [7:0] DEFAULT_CFG_PORT = spsc_pkg::CFG_PORT_DEFAULT
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Modem inputs
  input  wire logic        port_a_clear_to_send_n,
  input  wire logic        port_b_clear_to_send_n,
  input  wire logic        port_a_set_ready_n,
  input  wire logic        port_b_set_ready_n,
  input  wire logic        port_a_carrier_det_n,
  input  wire logic        port_b_carrier_det_n,
  input  wire logic        port_a_ring_ind_n,
  input  wire logic        port_b_ring_ind_n,
  // Shared strap / output pins
  input  wire logic        port_a_req_to_send_n_i,
  output logic             port_a_req_to_send_n_o,
  output logic             port_a_req_to_send_n_oe_n,
  input  wire logic        port_a_term_ready_n_i,
  output logic             port_a_term_ready_n_o,
  output logic             port_a_term_ready_n_oe_n,
  input  wire logic        port_a_serial_out_i,
  output logic             port_a_serial_out_o,
  output logic             port_a_serial_out_oe_n,
  input  wire logic        port_b_serial_out_i,
  output logic             port_b_serial_out_o,
  output logic             port_b_serial_out_oe_n,
  // Output-only pins
  output logic             port_b_req_to_send_n,
  output logic             port_b_term_ready_n,
  // Transmit data from the serial cores
  input  wire logic        uart_a_txd,
  input  wire logic        uart_b_txd,
  // Configuration results
  output logic [7:0]       cfg_port_addr,
  output logic             floppy_default_en,
  output logic             serial_default_en,
  output logic             printer_default_en,
  output logic             rom_enable,
  output logic             clk48_enable_bit,
  output logic             straps_valid
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  spsc_sync_if #(.W(spsc_pkg::SYNC_W)) sif ();

  assign sif.raw = {port_b_serial_out_i, port_a_serial_out_i,
                    port_a_term_ready_n_i, port_a_req_to_send_n_i,
                    port_b_ring_ind_n, port_a_ring_ind_n,
                    port_b_carrier_det_n, port_a_carrier_det_n,
                    port_b_set_ready_n, port_a_set_ready_n,
                    port_b_clear_to_send_n, port_a_clear_to_send_n};

  spsc_sync #(.W(spsc_pkg::SYNC_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (sif)
  );

  logic [spsc_pkg::SYNC_W-1:0] lvl;
  assign lvl = sif.level;

  // ----------------------------------------------------------------
  // Strap capture sequencer
  // ----------------------------------------------------------------
  spsc_pkg::spsc_state_t state;
  logic [2:0]            settle_cnt;
  logic                  capture;

  initial
  begin
    if (spsc_pkg::SETTLE_CYCLES < 4 || spsc_pkg::SETTLE_CYCLES > 7)
      $error("spsc_top: SETTLE_CYCLES out of range");
  end

  // Wait for the synchroniser to fill before trusting pin levels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= spsc_pkg::ST_SETTLE;
      settle_cnt <= 3'h0;
    end
    else
    begin
      case (state)
        spsc_pkg::ST_SETTLE:
        begin
          settle_cnt <= settle_cnt + 3'h1;
          if (capture)
            state <= spsc_pkg::ST_RUN;
        end
        spsc_pkg::ST_RUN:
          state <= spsc_pkg::ST_RUN;
        default:
          state <= spsc_pkg::ST_SETTLE;
      endcase
    end
  end

  // Filtered strap levels settle on the fourth edge, so take them after it
  assign capture = (state == spsc_pkg::ST_SETTLE) &&
                   (settle_cnt == 3'(spsc_pkg::SETTLE_CYCLES));
  assign straps_valid = (state == spsc_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero-wait, always OKAY
  // ----------------------------------------------------------------
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       take;

  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Register the address phase of a write for its data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= take && hwrite;
      wr_addr <= {haddr[7:2], 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] chip_config_reg_24;
  logic [7:0] chip_config_reg_26;
  logic [3:0] hs_ctrl;

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_pend && (wr_addr == ofs);
  endfunction

  // Straps win over a software write in the capture cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      chip_config_reg_24 <= 8'h00;
    else if (capture)
    begin
      chip_config_reg_24 <= 8'h00;
      chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_PNP_CLR]  <= lvl[spsc_pkg::IN_STR_PNP];
      chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_ROM_EN]   <= lvl[spsc_pkg::IN_STR_ROM];
      chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_CLK48_EN] <= lvl[spsc_pkg::IN_STR_C48];
    end
    else if (wr_hit(spsc_pkg::OFS_CHIP_CFG_24) && straps_valid)
      chip_config_reg_24 <= hwdata[7:0] & spsc_pkg::CHIP_CONFIG_REG_24_WMASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      chip_config_reg_26 <= 8'h00;
    else if (capture)
    begin
      chip_config_reg_26 <= 8'h00;
      chip_config_reg_26[spsc_pkg::CHIP_CONFIG_REG_26_PORT_SEL] <= lvl[spsc_pkg::IN_STR_PORT];
    end
    else if (wr_hit(spsc_pkg::OFS_CHIP_CFG_26) && straps_valid)
      chip_config_reg_26 <= hwdata[7:0] & spsc_pkg::CHIP_CONFIG_REG_26_WMASK;
  end

  // Handshake control: bit set means the line is asserted (pin low)
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hs_ctrl <= spsc_pkg::CTRL_RESET;
    else if (wr_hit(spsc_pkg::OFS_HS_CTRL))
      hs_ctrl <= hwdata[3:0];
  end

  // ----------------------------------------------------------------
  // Configuration results
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_port_addr      <= DEFAULT_CFG_PORT;
      floppy_default_en  <= 1'b0;
      serial_default_en  <= 1'b0;
      printer_default_en <= 1'b0;
      rom_enable         <= 1'b0;
      clk48_enable_bit   <= 1'b0;
    end
    else
    begin
      cfg_port_addr <= chip_config_reg_26[spsc_pkg::CHIP_CONFIG_REG_26_PORT_SEL] ?
                       spsc_pkg::CFG_PORT_ALT : DEFAULT_CFG_PORT;
      floppy_default_en  <= straps_valid &&
                            !chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_PNP_CLR];
      serial_default_en  <= straps_valid &&
                            !chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_PNP_CLR];
      printer_default_en <= straps_valid &&
                            !chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_PNP_CLR];
      rom_enable         <= chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_ROM_EN];
      clk48_enable_bit   <= chip_config_reg_24[spsc_pkg::CHIP_CONFIG_REG_24_CLK48_EN];
    end
  end

  // ----------------------------------------------------------------
  // Modem pins
  // ----------------------------------------------------------------
  // Shared pins float until capture so the pull-downs set the straps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a_req_to_send_n_oe_n <= 1'b1;
      port_a_term_ready_n_oe_n  <= 1'b1;
      port_a_serial_out_oe_n    <= 1'b1;
      port_b_serial_out_oe_n    <= 1'b1;
    end
    else if (capture)
    begin
      port_a_req_to_send_n_oe_n <= 1'b0;
      port_a_term_ready_n_oe_n  <= 1'b0;
      port_a_serial_out_oe_n    <= 1'b0;
      port_b_serial_out_oe_n    <= 1'b0;
    end
  end

  // Active-low handshake and idle-high serial outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a_req_to_send_n_o <= 1'b1;
      port_a_term_ready_n_o  <= 1'b1;
      port_b_req_to_send_n   <= 1'b1;
      port_b_term_ready_n    <= 1'b1;
      port_a_serial_out_o    <= 1'b1;
      port_b_serial_out_o    <= 1'b1;
    end
    else
    begin
      port_a_req_to_send_n_o <= !hs_ctrl[spsc_pkg::CTRL_RTS_A];
      port_a_term_ready_n_o  <= !hs_ctrl[spsc_pkg::CTRL_DTR_A];
      port_b_req_to_send_n   <= !hs_ctrl[spsc_pkg::CTRL_RTS_B];
      port_b_term_ready_n    <= !hs_ctrl[spsc_pkg::CTRL_DTR_B];
      port_a_serial_out_o    <= uart_a_txd;
      port_b_serial_out_o    <= uart_b_txd;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Status bits read 1 while the modem line is asserted (pin low)
  function automatic logic [7:0] hs_stat(input logic cts_n,
                                         input logic dsr_n,
                                         input logic ri_n,
                                         input logic dcd_n);
    hs_stat = 8'h00;
    hs_stat[spsc_pkg::HS_CTS] = !cts_n;
    hs_stat[spsc_pkg::HS_DSR] = !dsr_n;
    hs_stat[spsc_pkg::HS_RI]  = !ri_n;
    hs_stat[spsc_pkg::HS_DCD] = !dcd_n;
  endfunction

  logic [7:0] rd_mux;

  always_comb
  begin
    case ({haddr[7:2], 2'b00})
      spsc_pkg::OFS_CHIP_CFG_24: rd_mux = chip_config_reg_24;
      spsc_pkg::OFS_CHIP_CFG_26: rd_mux = chip_config_reg_26;
      spsc_pkg::OFS_HS_STAT_A:
        rd_mux = hs_stat(lvl[spsc_pkg::IN_CTS_A], lvl[spsc_pkg::IN_DSR_A],
                         lvl[spsc_pkg::IN_RI_A], lvl[spsc_pkg::IN_DCD_A]);
      spsc_pkg::OFS_HS_STAT_B:
        rd_mux = hs_stat(lvl[spsc_pkg::IN_CTS_B], lvl[spsc_pkg::IN_DSR_B],
                         lvl[spsc_pkg::IN_RI_B], lvl[spsc_pkg::IN_DCD_B]);
      spsc_pkg::OFS_HS_CTRL:     rd_mux = {4'h0, hs_ctrl};
      spsc_pkg::OFS_CFG_PORT:    rd_mux = cfg_port_addr;
      default:                   rd_mux = 8'h00;
    endcase
  end

  // Sampled in the address phase, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= {24'h00_0000, rd_mux};
  end

endmodule

/* File: spsc_props.sv */
`timescale 1ns/1ps

// --------------------------------------------------
// Strap capture and handshake pin checker
// --------------------------------------------------
module spsc_props #(
  parameter logic [7:0] DEFAULT_CFG_PORT = spsc_pkg::CFG_PORT_DEFAULT
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        port_a_clear_to_send_n,
  input wire logic        port_a_req_to_send_n_i,
  input wire logic        port_a_req_to_send_n_o,
  input wire logic        port_a_req_to_send_n_oe_n,
  input wire logic        port_a_term_ready_n_i,
  input wire logic        port_a_term_ready_n_o,
  input wire logic        port_a_term_ready_n_oe_n,
  input wire logic        port_a_serial_out_i,
  input wire logic        port_a_serial_out_oe_n,
  input wire logic        port_b_serial_out_i,
  input wire logic        port_b_serial_out_oe_n,
  input wire logic        port_b_req_to_send_n,
  input wire logic        port_b_term_ready_n,
  input wire logic [7:0]  cfg_port_addr,
  input wire logic        floppy_default_en,
  input wire logic        serial_default_en,
  input wire logic        printer_default_en,
  input wire logic        rom_enable,
  input wire logic        clk48_enable_bit,
  input wire logic        straps_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Read of port A status taken on the bus
  logic rd_a;
  assign rd_a = hsel && hready && htrans[1] && !hwrite
                && haddr == spsc_pkg::OFS_HS_STAT_A;

  // Straps sit still from reset, so depth 3 sees the captured level
  a_pins_undriven: assert property (!straps_valid |->
    port_a_req_to_send_n_oe_n && port_a_term_ready_n_oe_n
    && port_a_serial_out_oe_n && port_b_serial_out_oe_n)
    else $error("shared pin driven before capture");
  a_capture_once: assert property (straps_valid |=> straps_valid)
    else $error("capture flag dropped");
  a_port_select: assert property ($rose(straps_valid) |=>
    cfg_port_addr == ($past(port_a_req_to_send_n_i, 3)
    ? spsc_pkg::CFG_PORT_ALT : DEFAULT_CFG_PORT))
    else $error("config port address wrong");
  a_pnp_clear: assert property ($rose(straps_valid) |=>
    {floppy_default_en, serial_default_en, printer_default_en}
    == {3{!$past(port_a_term_ready_n_i, 3)}})
    else $error("default enables wrong");
  a_rom_strap: assert property ($rose(straps_valid) |=>
    rom_enable == $past(port_a_serial_out_i, 3))
    else $error("rom enable wrong");
  a_clk48_strap: assert property ($rose(straps_valid) |=>
    clk48_enable_bit == $past(port_b_serial_out_i, 3))
    else $error("48 MHz enable wrong");
  a_send_asserted: assert property ($rose(straps_valid) |->
    !port_a_req_to_send_n_o && !port_a_req_to_send_n_oe_n
    && !port_b_req_to_send_n)
    else $error("send request not asserted");
  a_ready_asserted: assert property ($rose(straps_valid) |->
    !port_a_term_ready_n_o && !port_a_term_ready_n_oe_n
    && !port_b_term_ready_n)
    else $error("terminal ready not asserted");
  a_cts_status: assert property (
    $stable(port_a_clear_to_send_n) [*6] ##0 rd_a
    |=> hrdata[spsc_pkg::HS_CTS] == !$past(port_a_clear_to_send_n))
    else $error("clear to send status wrong");

  c_capture: cover property ($rose(straps_valid));
  c_status_read: cover property (rd_a);
  c_alt_port: cover property (cfg_port_addr == spsc_pkg::CFG_PORT_ALT);
endmodule

/* File: spsc_modem.sv */
`timescale 1ns/1ps

// --------------------------------------------------
// Modem: drives handshake lines, lag cycles late
// --------------------------------------------------
module spsc_modem (
  input  wire logic       hclk,
  input  wire logic [7:0] want,
  input  wire logic [3:0] lag,
  output logic      [7:0] line_n
);
  logic [7:0] held = 8'hFF;
  logic [3:0] cnt  = 4'h0;

  // Asserted condition drives the line low; a slow modem waits lag cycles
  always_ff @(posedge hclk)
  begin
    if (held == ~want)
      cnt <= 4'h0;
    else if (cnt >= lag)
      held <= ~want;
    else
      cnt <= cnt + 4'h1;
  end
  assign line_n = held;
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        uart_a_txd = 1'b1;
  logic        uart_b_txd = 1'b1;
  logic [3:0]  strap = 4'h0;
  logic [7:0]  want = 8'h00;
  logic [3:0]  lag = 4'h0;
  int          errors = 0;
  int          n_checks = 0;
  wire logic   hready, hreadyout, hresp, straps_valid, rom_enable;
  wire logic   floppy_default_en, serial_default_en, printer_default_en;
  wire logic   clk48_enable_bit, port_b_req_to_send_n, port_b_term_ready_n;
  wire logic   port_a_req_to_send_n_i, port_a_req_to_send_n_o;
  wire logic   port_a_req_to_send_n_oe_n, port_a_term_ready_n_i;
  wire logic   port_a_term_ready_n_o, port_a_term_ready_n_oe_n;
  wire logic   port_a_serial_out_i, port_a_serial_out_o;
  wire logic   port_a_serial_out_oe_n, port_b_serial_out_i;
  wire logic   port_b_serial_out_o, port_b_serial_out_oe_n;
  wire logic   port_a_clear_to_send_n, port_a_set_ready_n;
  wire logic   port_a_ring_ind_n, port_a_carrier_det_n;
  wire logic   port_b_clear_to_send_n, port_b_set_ready_n;
  wire logic   port_b_ring_ind_n, port_b_carrier_det_n;
  wire logic [31:0] hrdata;
  wire logic [7:0]  cfg_port_addr;

  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  // Undriven shared pins fall to the strap resistor level
  assign port_a_req_to_send_n_i = port_a_req_to_send_n_oe_n ?
                                  strap[0] : port_a_req_to_send_n_o;
  assign port_a_term_ready_n_i = port_a_term_ready_n_oe_n ?
                                 strap[1] : port_a_term_ready_n_o;
  assign port_a_serial_out_i = port_a_serial_out_oe_n ?
                               strap[2] : port_a_serial_out_o;
  assign port_b_serial_out_i = port_b_serial_out_oe_n ?
                               strap[3] : port_b_serial_out_o;

  spsc_top spsc_top_i (.*);
  spsc_modem spsc_modem_i (
    .hclk   (hclk),
    .want   (want),
    .lag    (lag),
    .line_n ({port_b_carrier_det_n, port_b_ring_ind_n, port_b_set_ready_n,
              port_b_clear_to_send_n, port_a_carrier_det_n,
              port_a_ring_ind_n, port_a_set_ready_n, port_a_clear_to_send_n})
  );

  // Transmit data keeps toggling so the serial paths see traffic
  always @(posedge hclk)
    {uart_a_txd, uart_b_txd} <= 2'($urandom);

  // --------------------------------------------------
  // Bus master, checks and expectations
  // --------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] exp_chip_config_reg_24(input logic [3:0] s);
    return {24'h0, 1'b0, s[3], 4'h0, s[2], s[1]};
  endfunction

  function automatic logic [31:0] exp_stat(input logic [3:0] w);
    return {24'h0, w, 4'h0};
  endfunction

  task automatic summarize();
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the roughly 400 cycles the run needs
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    summarize();
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial
  begin
    logic [31:0] q;
    logic [31:0] d;
    logic [3:0]  s;
    void'($urandom(8));
    for (int r = 0; r < 5; r++)
    begin
      s = (r == 0) ? 4'h0 : (r == 1) ? 4'hF : 4'($urandom);
      @(posedge hclk);
      strap <= s;
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("oe_n", 32'hF, {port_a_req_to_send_n_oe_n, port_a_term_ready_n_oe_n,
          port_a_serial_out_oe_n, port_b_serial_out_oe_n});
      hresetn <= 1'b1;
      for (int i = 0; i < 20 && straps_valid !== 1'b1; i++) @(posedge hclk);
      repeat (2) @(posedge hclk);
      strap <= ~s;
      chk("cfg_port_addr", s[0] ? spsc_pkg::CFG_PORT_ALT
          : spsc_pkg::CFG_PORT_DEFAULT, cfg_port_addr);
      chk("default_en", {3{~s[1]}}, {floppy_default_en, serial_default_en,
          printer_default_en});
      chk("rom_enable", s[2], rom_enable);
      chk("clk48_enable", s[3], clk48_enable_bit);
      chk("hs_pins", 0, {port_a_req_to_send_n_i, port_a_term_ready_n_i,
          port_b_req_to_send_n, port_b_term_ready_n});
      // Transmit data seen at one edge must reach the pins one cycle later
      d = {30'h0, uart_a_txd, uart_b_txd};
      @(posedge hclk);
      chk("serial_out", d, {port_a_serial_out_i, port_b_serial_out_i});
      repeat (6) @(posedge hclk);
      xfer(spsc_pkg::OFS_CHIP_CFG_24, 1'b0, 32'h0, q);
      chk("chip_config_reg_24", exp_chip_config_reg_24(s), q);
      xfer(spsc_pkg::OFS_CHIP_CFG_26, 1'b0, 32'h0, q);
      chk("chip_config_reg_26", {25'h0, s[0], 6'h0}, q);
      xfer(spsc_pkg::OFS_CFG_PORT, 1'b0, 32'h0, q);
      chk("cfg_port", s[0] ? 32'(spsc_pkg::CFG_PORT_ALT)
          : 32'(spsc_pkg::CFG_PORT_DEFAULT), q);
    end
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      xfer(spsc_pkg::OFS_CHIP_CFG_24, 1'b1, d, q);
      xfer(spsc_pkg::OFS_CHIP_CFG_24, 1'b0, 32'h0, q);
      chk("chip_config_reg_24_rw", d & 32'h43, q);
      chk("rom_clk48", {d[1], d[6]}, {rom_enable, clk48_enable_bit});
      chk("default_en_rw", {3{~d[0]}}, {floppy_default_en,
          serial_default_en, printer_default_en});
    end
    // Software select of the alternate configuration port, both ways
    for (int i = 0; i < 2; i++)
    begin
      xfer(spsc_pkg::OFS_CHIP_CFG_26, 1'b1, (i == 0) ? 32'h0 : 32'hFF, q);
      xfer(spsc_pkg::OFS_CFG_PORT, 1'b0, 32'h0, q);
      chk("cfg_port_rw", (i == 0) ? 32'(spsc_pkg::CFG_PORT_DEFAULT)
          : 32'(spsc_pkg::CFG_PORT_ALT), q);
    end
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'hFF : $urandom;
      @(posedge hclk);
      want <= d[7:0];
      lag <= 4'(i % 4);
      repeat (16) @(posedge hclk);
      xfer(spsc_pkg::OFS_HS_STAT_A, 1'b0, 32'h0, q);
      chk("stat_a", exp_stat(d[3:0]), q);
      xfer(spsc_pkg::OFS_HS_STAT_B, 1'b0, 32'h0, q);
      chk("stat_b", exp_stat(d[7:4]), q);
    end
    for (int i = 0; i < 2; i++)
    begin
      xfer(spsc_pkg::OFS_HS_CTRL, 1'b1, (i == 0) ? 32'h0 : 32'hF, q);
      repeat (2) @(posedge hclk);
      chk("hs_ctrl_pins", (i == 0) ? 32'hF : 32'h0,
          {port_a_req_to_send_n_i, port_a_term_ready_n_i,
          port_b_req_to_send_n, port_b_term_ready_n});
    end
    xfer(8'h1C, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("resp", 32'h2, {hreadyout, hresp});
    summarize();
  end
endmodule

bind spsc_top spsc_props #(.DEFAULT_CFG_PORT(DEFAULT_CFG_PORT)) spsc_props_i (.*);
